// ---- dcc_cfg.svh ----
// Summary of operation
// - Two independent comparator channels, each with its own control register and its own bits in one status register.
// - A comparator result is one when its positive input is above its negative input, and zero otherwise.
// - Each raw comparator result passes through flip-flops on the bus clock before software can read it.
// - Comparator zero's synchronized output reads at status bit 2 and reads zero while comparator zero is disabled.
// - Comparator one's synchronized output reads at status bit 3 and reads zero while comparator one is disabled.
// - Hardware sets the comparator zero change flag, status bit 0, on every change of its synchronized result while comparator zero is enabled.
// - Hardware sets the comparator one change flag, status bit 1, on every change of its synchronized result while comparator one is enabled.
// - Control bit 1 enables a comparator's interrupt, so that its set change flag raises the interrupt request.
// - Writing one to a change flag clears it unless a change sets it in the same cycle, and writing zero leaves it as it is.
// - Control bit 4 selects the band-gap reference as negative input when one, the external pin when zero.
// - Control bit 2 turns the comparator hysteresis of about 20mV on when set and off when clear.
// - All control and status registers reset to zero, leaving both comparators, hysteresis and interrupts off.
// - Control zero sits at offset 0x00, control one at 0x04 and the shared status at 0x08.
`ifndef DCC_CFG_SVH
`define DCC_CFG_SVH

`define DCC_AW 8
`define DCC_DW 32
`define DCC_NCH 2

`define DCC_OFF_CTRL0 8'h00
`define DCC_OFF_CTRL1 8'h04
`define DCC_OFF_STATUS 8'h08
`define DCC_OFF_CLEAR 8'h0C
`define DCC_OFF_IEN 8'h10
`define DCC_OFF_READY 8'h14

`define DCC_CR_EN 0
`define DCC_CR_IE 1
`define DCC_CR_HYS 2
`define DCC_CR_NSEL 4

`define DCC_SR_FLAG0 0
`define DCC_SR_CO0 2

`define DCC_RESET_WORD 32'h0000_0000

`define DCC_CLK_NS 4
`define DCC_SETTLE_NS 2000
`define DCC_SETTLE_CYC ((`DCC_SETTLE_NS + `DCC_CLK_NS - 1) / `DCC_CLK_NS)
`define DCC_CNT_W 10

`endif

// ---- dcc_pkg.sv ----
`include "dcc_cfg.svh"
package dcc_pkg;

  typedef struct packed {
    logic nsel;
    logic hys;
    logic ie;
    logic en;
  } dcc_ctrl_type;

  typedef struct packed {
    dcc_ctrl_type ctrl;
    logic co;
    logic flag;
    logic settled;
  } dcc_chan_out_type;

  typedef struct packed {
    dcc_ctrl_type ctrl;
    logic prev;
    logic flag;
    logic [`DCC_CNT_W-1:0] cnt;
  } dcc_chan_state_type;

  typedef struct packed {
    logic [`DCC_NCH-1:0] s1;
    logic [`DCC_NCH-1:0] s2;
  } dcc_sync_state_type;

  typedef struct packed {
    logic [`DCC_DW-1:0] rdata;
    logic irq;
    logic [`DCC_NCH-1:0] en;
    logic [`DCC_NCH-1:0] hys;
    logic [`DCC_NCH-1:0] nsel;
  } dcc_top_state_type;

endpackage

// ---- dcc_sync.sv ----
`timescale 1ns/10ps
`include "dcc_cfg.svh"
module dcc_sync
  import dcc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Raw comparator results
  input wire logic [`DCC_NCH-1:0] raw_i,
  // Synchronized results
  output logic [`DCC_NCH-1:0] sync_o
);

  dcc_sync_state_type st_r;
  dcc_sync_state_type st_nxt;

  // First stage feeds only the second stage
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = raw_i;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign sync_o = st_r.s2;

endmodule

// ---- dcc_chan.sv ----
`timescale 1ns/10ps
`include "dcc_cfg.svh"
module dcc_chan
  import dcc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Register writes
  input wire logic ctrl_wr_i,
  input wire dcc_ctrl_type ctrl_i,
  input wire logic ie_wr_i,
  input wire logic ie_i,
  input wire logic clr_i,
  // Synchronized comparator result
  input wire logic sync_i,
  // Channel view
  output dcc_chan_out_type out_o
);

  dcc_chan_state_type st_r;
  dcc_chan_state_type st_nxt;
  logic chg;

  // Disabled comparators flap while powering up, so only enabled ones flag
  assign chg = st_r.ctrl.en & (sync_i ^ st_r.prev);

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.prev = sync_i;
    if (st_r.cnt != '0)
      st_nxt.cnt = st_r.cnt - 1'b1;
    if (ctrl_wr_i)
    begin
      st_nxt.ctrl = ctrl_i;
      if (ctrl_i.en && !st_r.ctrl.en)
        st_nxt.cnt = `DCC_CNT_W'(`DCC_SETTLE_CYC);
    end
    if (ie_wr_i)
      st_nxt.ctrl.ie = ie_i;
    st_nxt.flag = chg | (st_r.flag & ~clr_i);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign out_o.ctrl = st_r.ctrl;
  assign out_o.co = st_r.ctrl.en & sync_i;
  assign out_o.flag = st_r.flag;
  assign out_o.settled = st_r.ctrl.en & (st_r.cnt == '0);

endmodule

// ---- dcc_top.sv ----
`timescale 1ns/10ps
`include "dcc_cfg.svh"
module dcc_top
  import dcc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [`DCC_AW-1:0] addr_i,
  input wire logic [`DCC_DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [`DCC_DW-1:0] rdata_o,
  // Analog comparator side
  input wire logic [`DCC_NCH-1:0] cmp_raw_i,
  output logic [`DCC_NCH-1:0] comparator_enable_o,
  output logic [`DCC_NCH-1:0] hysteresis_enable_o,
  output logic [`DCC_NCH-1:0] negative_input_select_o,
  // Interrupt
  output logic irq_o
);

  dcc_top_state_type st_r;
  dcc_top_state_type st_nxt;
  dcc_chan_out_type ch_out [`DCC_NCH];
  logic [`DCC_NCH-1:0] sync;
  logic [`DCC_NCH-1:0] ctrl_wr;
  logic [`DCC_NCH-1:0] clr;
  logic [`DCC_NCH-1:0] flag_v;
  logic [`DCC_NCH-1:0] ie_v;
  logic [`DCC_NCH-1:0] co_v;
  logic [`DCC_NCH-1:0] en_v;
  logic [`DCC_NCH-1:0] hys_v;
  logic [`DCC_NCH-1:0] nsel_v;
  logic [`DCC_NCH-1:0] rdy_v;
  logic wr_status;
  logic wr_clear;
  logic wr_ien;
  dcc_ctrl_type ctrl_w;
  logic [`DCC_DW-1:0] rd_word;
  logic irq_src;

  function automatic logic [`DCC_DW-1:0] ctrl_word(input dcc_ctrl_type c);
    logic [`DCC_DW-1:0] w;
    w = `DCC_RESET_WORD;
    w[`DCC_CR_EN] = c.en;
    w[`DCC_CR_IE] = c.ie;
    w[`DCC_CR_HYS] = c.hys;
    w[`DCC_CR_NSEL] = c.nsel;
    return w;
  endfunction

  // Comparator results enter from the analog side, asynchronous to the bus clock
  dcc_sync u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .raw_i(cmp_raw_i),
    .sync_o(sync)
  );

  // Address decode
  assign ctrl_wr[0] = wr_i && (addr_i == `DCC_OFF_CTRL0);
  assign ctrl_wr[1] = wr_i && (addr_i == `DCC_OFF_CTRL1);
  assign wr_status = wr_i && (addr_i == `DCC_OFF_STATUS);
  assign wr_clear = wr_i && (addr_i == `DCC_OFF_CLEAR);
  assign wr_ien = wr_i && (addr_i == `DCC_OFF_IEN);

  // Only the defined control bits are taken, the rest of the word is dropped
  assign ctrl_w.en = wdata_i[`DCC_CR_EN];
  assign ctrl_w.ie = wdata_i[`DCC_CR_IE];
  assign ctrl_w.hys = wdata_i[`DCC_CR_HYS];
  assign ctrl_w.nsel = wdata_i[`DCC_CR_NSEL];

  genvar gi;
  generate
    for (gi = 0; gi < `DCC_NCH; gi = gi + 1)
    begin : g_ch
      // Output bits of status are never written; only flag bits clear
      assign clr[gi] = (wr_status && wdata_i[`DCC_SR_FLAG0 + gi]) ||
                       (wr_clear && wdata_i[`DCC_SR_FLAG0 + gi]);

      dcc_chan u_chan (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .ctrl_wr_i(ctrl_wr[gi]),
        .ctrl_i(ctrl_w),
        .ie_wr_i(wr_ien),
        .ie_i(wdata_i[gi]),
        .clr_i(clr[gi]),
        .sync_i(sync[gi]),
        .out_o(ch_out[gi])
      );

      assign flag_v[gi] = ch_out[gi].flag;
      assign ie_v[gi] = ch_out[gi].ctrl.ie;
      assign co_v[gi] = ch_out[gi].co;
      assign en_v[gi] = ch_out[gi].ctrl.en;
      assign hys_v[gi] = ch_out[gi].ctrl.hys;
      assign nsel_v[gi] = ch_out[gi].ctrl.nsel;
      assign rdy_v[gi] = ch_out[gi].settled;
    end
  endgenerate

  // Read multiplexer; unmapped offsets read zero
  always_comb
  begin
    rd_word = `DCC_RESET_WORD;
    case (addr_i)
      `DCC_OFF_CTRL0: rd_word = ctrl_word(ch_out[0].ctrl);
      `DCC_OFF_CTRL1: rd_word = ctrl_word(ch_out[1].ctrl);
      `DCC_OFF_STATUS:
      begin
        rd_word[`DCC_SR_FLAG0 +: `DCC_NCH] = flag_v;
        rd_word[`DCC_SR_CO0 +: `DCC_NCH] = co_v;
      end
      `DCC_OFF_IEN: rd_word[`DCC_NCH-1:0] = ie_v;
      `DCC_OFF_READY: rd_word[`DCC_NCH-1:0] = rdy_v;
      default: rd_word = `DCC_RESET_WORD;
    endcase
  end

  // Read data stands for exactly one cycle, zero otherwise
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rdata = rd_i ? rd_word : `DCC_RESET_WORD;
    st_nxt.irq = |(flag_v & ie_v);
    st_nxt.en = en_v;
    st_nxt.hys = hys_v;
    st_nxt.nsel = nsel_v;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign rdata_o = st_r.rdata;
  assign irq_o = st_r.irq;
  assign comparator_enable_o = st_r.en;
  assign hysteresis_enable_o = st_r.hys;
  assign negative_input_select_o = st_r.nsel;

  // Checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  assign irq_src = |(flag_v & ie_v);

  // The second flop still shows reset until the second edge after release
  property p_sync_delay;
    ($past(rst_n_i, 2) && $past(rst_n_i)) |-> (sync == $past(cmp_raw_i, 2));
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("synchronized result does not follow raw input by two cycles");

  property p_co0_gated;
    (rd_i && addr_i == `DCC_OFF_STATUS && !en_v[0]) |=> (rdata_o[`DCC_SR_CO0] == 1'b0);
  endproperty
  a_co0_gated: assert property (p_co0_gated)
    else $error("comparator zero output reads one while disabled");

  property p_co1_gated;
    (rd_i && addr_i == `DCC_OFF_STATUS) |=> (rdata_o[`DCC_SR_CO0 + 1] == ($past(en_v[1]) & $past(sync[1])));
  endproperty
  a_co1_gated: assert property (p_co1_gated)
    else $error("comparator one output bit wrong");

  property p_flag0_set;
    (en_v[0] && (sync[0] != $past(sync[0]))) |=> flag_v[0];
  endproperty
  a_flag0_set: assert property (p_flag0_set)
    else $error("comparator zero change did not set its flag");

  property p_flag1_set;
    (en_v[1] && $changed(sync[1]) && clr[1]) |=> flag_v[1];
  endproperty
  a_flag1_set: assert property (p_flag1_set)
    else $error("comparator one change lost against a clear");

  property p_irq;
    ##1 irq_o == $past(irq_src);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt does not match enabled flags");

  property p_irq_hold;
    (flag_v[0] && ie_v[0]) [*2] |-> irq_o;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("enabled flag did not raise the interrupt");

  property p_clear;
    (wr_status && wdata_i[`DCC_SR_FLAG0] && !(en_v[0] && $changed(sync[0]))) |=> !flag_v[0];
  endproperty
  a_clear: assert property (p_clear)
    else $error("write one did not clear flag zero");

  property p_keep;
    (wr_status && !wdata_i[`DCC_SR_FLAG0] && !wr_clear && flag_v[0]) |=> flag_v[0];
  endproperty
  a_keep: assert property (p_keep)
    else $error("write zero disturbed flag zero");

  property p_nsel;
    (ctrl_wr[0]) |=> ##1 (negative_input_select_o[0] == $past(wdata_i[`DCC_CR_NSEL], 2));
  endproperty
  a_nsel: assert property (p_nsel)
    else $error("negative input select not driven from control bit 4");

  property p_hys;
    (ctrl_wr[1]) |=> ##1 (hysteresis_enable_o[1] == $past(wdata_i[`DCC_CR_HYS], 2));
  endproperty
  a_hys: assert property (p_hys)
    else $error("hysteresis enable not driven from control bit 2");

  property p_rd_once;
    !$past(rd_i) |-> (rdata_o == `DCC_RESET_WORD);
  endproperty
  a_rd_once: assert property (p_rd_once)
    else $error("read data present without a read");

  property p_resv;
    rd_i |=> (rdata_o[`DCC_DW-1:`DCC_CR_NSEL+1] == '0);
  endproperty
  a_resv: assert property (p_resv)
    else $error("reserved read bits not zero");

  property p_co0_value;
    (rd_i && addr_i == `DCC_OFF_STATUS) |=> (rdata_o[`DCC_SR_CO0] == ($past(en_v[0]) & $past(sync[0])));
  endproperty
  a_co0_value: assert property (p_co0_value)
    else $error("comparator zero output bit wrong");

  property p_status_flags;
    (rd_i && addr_i == `DCC_OFF_STATUS) |=> (rdata_o[`DCC_SR_FLAG0 +: `DCC_NCH] == $past(flag_v));
  endproperty
  a_status_flags: assert property (p_status_flags)
    else $error("status flag bits do not show the flags");

  property p_flag1_chg;
    (en_v[1] && $changed(sync[1])) |=> flag_v[1];
  endproperty
  a_flag1_chg: assert property (p_flag1_chg)
    else $error("comparator one change did not set its flag");

  property p_flag0_quiet;
    (!flag_v[0] && !(en_v[0] && $changed(sync[0]))) |=> !flag_v[0];
  endproperty
  a_flag0_quiet: assert property (p_flag0_quiet)
    else $error("flag zero set without a change");

  property p_flag1_quiet;
    (!flag_v[1] && !(en_v[1] && $changed(sync[1]))) |=> !flag_v[1];
  endproperty
  a_flag1_quiet: assert property (p_flag1_quiet)
    else $error("flag one set without a change");

  property p_clear1;
    (clr[1] && !(en_v[1] && $changed(sync[1]))) |=> !flag_v[1];
  endproperty
  a_clear1: assert property (p_clear1)
    else $error("write one did not clear flag one");

  property p_ctrl1_read;
    (rd_i && addr_i == `DCC_OFF_CTRL1) |=> (rdata_o[`DCC_CR_IE] == $past(ie_v[1]));
  endproperty
  a_ctrl1_read: assert property (p_ctrl1_read)
    else $error("control one read does not show its interrupt enable");

  property p_en0_out;
    (ctrl_wr[0]) |=> ##1 (comparator_enable_o[0] == $past(wdata_i[`DCC_CR_EN], 2));
  endproperty
  a_en0_out: assert property (p_en0_out)
    else $error("comparator zero enable not driven from control bit 0");

  property p_reset_quiet;
    !$past(rst_n_i) |-> (irq_o == 1'b0 && comparator_enable_o == '0 && rdata_o == '0);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs not quiet right after reset");

  property p_ie_alias;
    wr_ien |=> (ie_v == $past(wdata_i[`DCC_NCH-1:0]));
  endproperty
  a_ie_alias: assert property (p_ie_alias)
    else $error("interrupt enable write not taken");

  property p_hys0;
    (ctrl_wr[0]) |=> ##1 (hysteresis_enable_o[0] == $past(wdata_i[`DCC_CR_HYS], 2));
  endproperty
  a_hys0: assert property (p_hys0)
    else $error("hysteresis zero not driven from control bit 2");

  property p_nsel1;
    (ctrl_wr[1]) |=> ##1 (negative_input_select_o[1] == $past(wdata_i[`DCC_CR_NSEL], 2));
  endproperty
  a_nsel1: assert property (p_nsel1)
    else $error("negative input select one not driven from control bit 4");

  c_flag0: cover property (en_v[0] ##1 flag_v[0]);
  c_irq: cover property (!irq_o ##1 irq_o);
  c_clear: cover property (flag_v[1] ##1 clr[1] ##1 !flag_v[1]);
  c_set_wins: cover property (clr[0] && en_v[0] && $changed(sync[0]));

endmodule

// ---- dcc_cmp_model.sv ----
`timescale 1ns/10ps
module dcc_cmp_model #(
  parameter int BG_MV = 1200,
  parameter int HYS_MV = 20
) (
  // Clock
  input wire logic ref_clk_i,
  // Controls from the block
  input wire logic [1:0] en_i,
  input wire logic [1:0] hys_i,
  input wire logic [1:0] nsel_i,
  // Input voltages in mV
  input wire logic [1:0][15:0] pos_i,
  input wire logic [1:0][15:0] neg_i,
  // Raw results
  output logic [1:0] raw_o
);
  logic [1:0] out_r = 2'h0;
  logic junk_r = 1'b0;
  int n;
  int h;
  // A disabled comparator wanders, so no flag or output comes for free
  always @(posedge ref_clk_i)
    junk_r <= ~junk_r;
  // Updates on the falling edge, unrelated to the sampling edge
  always @(negedge ref_clk_i)
  begin
    for (int i = 0; i < 2; i++)
    begin
      n = nsel_i[i] ? BG_MV : int'(neg_i[i]);
      h = hys_i[i] ? HYS_MV / 2 : 0;
      if (int'(pos_i[i]) > n + h)
        out_r[i] <= 1'b1;
      else if (int'(pos_i[i]) + h <= n)
        out_r[i] <= 1'b0;
    end
  end
  assign raw_o = (out_r & en_i) | (~en_i & {2{junk_r}});
endmodule

// ---- dcc_tb_top.sv ----
`timescale 1ns/10ps
`include "dcc_cfg.svh"
`define CHK(w, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; $display("[FAIL] %s exp %h got %h", w, e, g); end end
module dcc_tb_top;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [`DCC_AW-1:0] addr = '0;
  logic [`DCC_DW-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [`DCC_DW-1:0] rdata;
  logic [1:0] raw;
  logic [1:0] en;
  logic [1:0] hys;
  logic [1:0] nsel;
  logic irq;
  logic [1:0][15:0] pos = {16'h044C, 16'h01F4};
  logic [1:0][15:0] neg = {16'h01F4, 16'h03E8};
  int bad_count = 0;
  int check_count = 0;

  always #2 ref_clk_i = ~ref_clk_i;

  dcc_top uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .cmp_raw_i(raw), .comparator_enable_o(en), .hysteresis_enable_o(hys),
    .negative_input_select_o(nsel), .irq_o(irq));
  dcc_cmp_model model (.ref_clk_i(ref_clk_i), .en_i(en), .hys_i(hys), .nsel_i(nsel), .pos_i(pos),
    .neg_i(neg), .raw_o(raw));

  task automatic wrt(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic rst();
    rst_n_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Hang guard, far beyond the whole sequence
  initial
  begin
    #200000;
    bad_count++;
    print_verdict();
  end

  initial
  begin
    rst();
    rchk(8'h00, 32'h0000_0000);
    rchk(8'h08, 32'h0000_0000);
    `CHK("irq", 1'b0, irq)
    wrt(8'h00, 32'hFFFF_FFFF);
    wrt(8'h20, 32'hFFFF_FFFF);
    rchk(8'h00, 32'h0000_0017);
    rchk(8'h04, 32'h0000_0000);
    rchk(8'h20, 32'h0000_0000);
    cyc(1);
    `CHK("rdata idle", 32'h0000_0000, rdata)
    `CHK("ports", 6'h15, {en, hys, nsel})
    wrt(8'h00, 32'h0000_0000);
    $display("end map");
    wrt(8'h00, 32'h0000_0001);
    wrt(8'h04, 32'h0000_0001);
    rchk(8'h14, 32'h0000_0000);
    cyc(500);
    rchk(8'h14, 32'h0000_0003);
    wrt(8'h08, 32'h0000_0003);
    rchk(8'h08, 32'h0000_0008);
    $display("end settle");
    @(posedge ref_clk_i) pos[0] <= 16'h05DC;
    cyc(6);
    rchk(8'h08, 32'h0000_000D);
    `CHK("irq", 1'b0, irq)
    wrt(8'h08, 32'h0000_000C);
    rchk(8'h08, 32'h0000_000D);
    wrt(8'h08, 32'h0000_0001);
    rchk(8'h08, 32'h0000_000C);
    wrt(8'h00, 32'h0000_0003);
    @(posedge ref_clk_i) pos[0] <= 16'h01F4;
    cyc(6);
    rchk(8'h08, 32'h0000_0009);
    `CHK("irq", 1'b1, irq)
    wrt(8'h0C, 32'h0000_0001);
    cyc(2);
    `CHK("irq", 1'b0, irq)
    rchk(8'h10, 32'h0000_0001);
    $display("end chan0");
    wrt(8'h04, 32'h0000_0013);
    cyc(6);
    rchk(8'h08, 32'h0000_0002);
    @(posedge ref_clk_i) pos[1] <= 16'h0514;
    cyc(6);
    rchk(8'h08, 32'h0000_000A);
    `CHK("irq", 1'b1, irq)
    wrt(8'h10, 32'h0000_0000);
    cyc(2);
    `CHK("irq", 1'b0, irq)
    rchk(8'h04, 32'h0000_0011);
    wrt(8'h08, 32'h0000_0002);
    wrt(8'h04, 32'h0000_0017);
    @(posedge ref_clk_i) pos[1] <= 16'h04AB;
    cyc(6);
    rchk(8'h08, 32'h0000_0008);
    `CHK("hys", 2'h2, hys)
    wrt(8'h04, 32'h0000_0013);
    cyc(6);
    rchk(8'h08, 32'h0000_0002);
    $display("end chan1");
    // Disabled channel with a high input and a wandering raw line
    wrt(8'h08, 32'h0000_0003);
    wrt(8'h00, 32'h0000_0002);
    @(posedge ref_clk_i) pos[0] <= 16'h05DC;
    cyc(10);
    rchk(8'h08, 32'h0000_0000);
    `CHK("irq", 1'b0, irq)
    @(posedge ref_clk_i);
    rst();
    rchk(8'h04, 32'h0000_0000);
    rchk(8'h08, 32'h0000_0000);
    $display("end disable_reset");
    print_verdict();
  end
endmodule
